/* File: pmr_power_ctrl.v */
`timescale 1ns/1ns
`include "pmr_defines.vh"

// What this block does
// - Idle keeps oscillator and peripheral clocks, gates only core clock.
// - Idle holds core state, port pins and converter outputs unchanged.
// - Any enabled interrupt or hardware reset ends idle.
// - Power-down stops PLL and core clock.
// - Oscillator halts in power-down only if oscillator power-down bit set.
// - Interval counter may run in power-down; other peripherals shut down.
// - Power-down holds port levels and tri-states converter analog outputs.
// - Reset pin in power-down returns to normal, defaults, reset vector.
// - Power cycling loads defaults and starts about 128 ms later.
// - Interval counter interrupt ends power-down and resumes after entry.
// - Serial interrupt wakes power-down only if its wake enable is set.
// - Interrupt zero pin wakes power-down only if its wake enable set.
// - Hold reset below 2.45 V, then run 128 ms timer before release.
// - On falling supply keep reset held until supply below 1 V.
// - Program strobe pin is output, sampled low at reset release.
// - Strobe pin high at release selects normal mode and stored program.
// - Debug mode uses the same strap as download mode.
// - External access pin picks memory unless pulled high for emulation.
// - Software writes control bits to enter idle or power-down.
module pmr_power_ctrl #(
  parameter POR_CYCLES = `PMR_POR_CYCLES
) (
  input wire clock,
  input wire rst_b,
  input wire supply_ok,
  input wire supply_dead,
  input wire reset_pin_b,
  input wire irq_pending,
  input wire interval_counter_irq,
  input wire serial_irq,
  input wire external_interrupt_zero_pin,
  input wire program_strobe_pin_in,
  input wire external_access_pin,
  input wire emul_pullup_seen,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg core_reset,
  output reg core_clk_en,
  output reg pll_en,
  output reg osc_en,
  output reg periph_clk_en,
  output reg interval_counter_clk_en,
  output reg hold_state,
  output reg dac_out_hiz,
  output reg wake_irq_service,
  output reg download_mode,
  output reg ext_program_mem,
  output reg emulation_mode,
  output wire program_strobe_pin_oe
);

  // Mode encoding, mirrored in the status register's low two bits.
  // Run: every clock on. Idle: only the core clock is gated.
  // Power-down: PLL, core and peripheral clocks all stop, and the
  // oscillator follows the oscillator power-down bit.
  // Code 3 is never entered; the default branch steers it back to run.
  localparam ST_RUN = 2'd0;
  localparam ST_IDLE = 2'd1;
  localparam ST_PDOWN = 2'd2;

  // Every pin and supply level crosses in from outside the clock's
  // domain, so nothing but the second flop of each pair is read.
  // The added two-cycle lag is harmless next to the power-on hold.
  // Pin and supply synchronisers, two flops each
  reg [6:0] sync1_q;
  reg [6:0] sync2_q;
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sync1_q <= 7'h00;
      sync2_q <= 7'h00;
    end else begin
      sync1_q <= {supply_ok, supply_dead, reset_pin_b,
                  external_interrupt_zero_pin, program_strobe_pin_in,
                  external_access_pin, emul_pullup_seen};
      sync2_q <= sync1_q;
    end
  end
  wire s_sup_ok = sync2_q[6];
  wire s_sup_dead = sync2_q[5];
  wire s_rst_pin_b = sync2_q[4];
  wire s_external_interrupt_zero_pin = sync2_q[3];
  wire s_strobe = sync2_q[2];
  wire s_ea = sync2_q[1];
  wire s_emu = sync2_q[0];

  // Power-on reset: held until supply good, then counted hold
  // The counter restarts from zero each time the supply dips, so a
  // bouncing supply never shortens the hold.
  reg por_hold_q;
  reg [31:0] por_cnt_q;
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      por_hold_q <= 1'b1;
      por_cnt_q <= 32'h00000000;
    end else if (!por_hold_q) begin
      // A sagging supply re-arms the hold; it then stays asserted
      // all the way down, since the dead flag only deepens it
      if (!s_sup_ok || s_sup_dead) begin
        por_hold_q <= 1'b1;
        por_cnt_q <= 32'h00000000;
      end
    end else if (!s_sup_ok) begin
      por_cnt_q <= 32'h00000000;
    end else if (por_cnt_q >= POR_CYCLES - 1) begin
      por_hold_q <= 1'b0;
    end else begin
      por_cnt_q <= por_cnt_q + 32'h00000001;
    end
  end

  // Either source of reset forces the mode state and the control and wake-cause registers to their defaults,
  // and the pin is level-sensitive so a held button keeps it there
  wire any_reset = por_hold_q | ~s_rst_pin_b;

  // Control registers live with the mode machine because the mode
  // request bits and the reset defaults are decided in one place.
  // Registers
  reg [31:0] clkcfg_q;
  reg [31:0] pwrctl_q;
  reg [1:0] state_q;
  reg [3:0] wake_cause_q;
  reg rst_prev_q;

  // Address and data may arrive in either order; each is parked in
  // its own holding register and the write lands only once both are
  // in. Ready stays low while a response is pending, which keeps one
  // write in flight at a time.
  // AXI write: both channels captured, then one response
  reg aw_hold_q;
  reg w_hold_q;
  reg [31:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  assign s_axi_awready = ~aw_hold_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_hold_q & ~s_axi_bvalid;
  wire wr_go = aw_hold_q & w_hold_q & ~s_axi_bvalid;

  // Byte-lane merge honours the write strobes for the clock and power control registers
  function [31:0] merge;
    input [31:0] old;
    input [31:0] dat;
    input [3:0] strb;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        merge[i*8 +: 8] = strb[i] ? dat[i*8 +: 8] : old[i*8 +: 8];
      end
    end
  endfunction

  // Decodes the four register offsets; anything else, including a
  // nonzero upper address, answers with a slave error
  function mapped;
    input [31:0] a;
    begin
      mapped = (a[7:0] == `PMR_OFS_CLKCFG) | (a[7:0] == `PMR_OFS_PWRCTL) |
               (a[7:0] == `PMR_OFS_STATUS) | (a[7:0] == `PMR_OFS_WAKE);
      mapped = mapped & (a[31:8] == 24'h000000);
    end
  endfunction

  wire wr_pwr = wr_go & (awaddr_q[31:0] == {24'h0, `PMR_OFS_PWRCTL});
  wire wr_clk = wr_go & (awaddr_q[31:0] == {24'h0, `PMR_OFS_CLKCFG});
  wire wr_wake = wr_go & (awaddr_q[31:0] == {24'h0, `PMR_OFS_WAKE});
  wire [31:0] pwr_new = merge(pwrctl_q, wdata_q, wstrb_q);

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 32'h00000000;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      // Response is registered; it stands until the master takes it
      if (wr_go) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(awaddr_q) ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Wake sources, gated by their enables where the mode needs it
  // The interval counter always wakes; the serial and interrupt zero
  // sources need their enables. The pin is active low and synced.
  wire wk_ic = interval_counter_irq;
  wire wk_ser = serial_irq & pwrctl_q[`PMR_PC_SER_WAKE];
  wire wk_external_interrupt_zero_pin = ~s_external_interrupt_zero_pin & pwrctl_q[`PMR_PC_EXTERNAL_INTERRUPT_ZERO_PIN_WAKE];
  wire pd_wake = wk_ic | wk_ser | wk_external_interrupt_zero_pin;
  wire idle_wake = irq_pending | pd_wake;

  // Wake-cause clears are folded in first so that a wake arriving in
  // the same cycle as a write-one-to-clear still leaves its bit set
  wire [3:0] wake_kept = wr_wake ? (wake_cause_q & ~wdata_q[3:0]) :
                         wake_cause_q;

  // Mode state machine and software control bits
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_RUN;
      pwrctl_q <= `PMR_PWRCTL_RST;
      clkcfg_q <= `PMR_CLKCFG_RST;
      wake_cause_q <= 4'h0;
    end else if (any_reset) begin
      // Reset pin or supply returns everything to defaults
      // Writes while reset is held fall away; only the response goes out
      state_q <= ST_RUN;
      pwrctl_q <= `PMR_PWRCTL_RST;
      clkcfg_q <= `PMR_CLKCFG_RST;
      wake_cause_q <= 4'h0;
    end else begin
      if (wr_clk) begin
        clkcfg_q <= merge(clkcfg_q, wdata_q, wstrb_q);
      end
      wake_cause_q <= wake_kept; // Clear first, sets below override
      // Only run accepts a mode request: the core is the only writer
      // of these bits, and it cannot execute while idle or powered down.
      // Both request bits read back as zero once acted on.
      case (state_q)
        ST_RUN: begin
          if (wr_pwr) begin
            pwrctl_q <= pwr_new;
            // Wake wins so a same-cycle request never strands the chip
            if (pwr_new[`PMR_PC_PDOWN] && !pd_wake) begin
              state_q <= ST_PDOWN;
            end else if (pwr_new[`PMR_PC_IDLE] && !idle_wake) begin
              state_q <= ST_IDLE;
            end
            pwrctl_q[`PMR_PC_PDOWN] <= 1'b0;
            pwrctl_q[`PMR_PC_IDLE] <= 1'b0;
          end
        end
        ST_IDLE: begin
          // Any interrupt the core has enabled ends idle
          if (idle_wake) begin
            state_q <= ST_RUN;
            wake_cause_q[`PMR_WK_OTHER] <= 1'b1;
          end
        end
        ST_PDOWN: begin
          // Only the listed wake sources end power-down; the core then
          // services the interrupt and returns after the entry.
          if (pd_wake) begin
            state_q <= ST_RUN;
            wake_cause_q <= wake_kept | {1'b0, wk_external_interrupt_zero_pin, wk_ser, wk_ic};
          end
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  // Strap capture on the release of reset
  // The synced strobe level still shows the pin as it stood during
  // reset, since the output enable returns in that same cycle and the
  // pin's new level takes two more cycles to reach the capture.
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_prev_q <= 1'b1;
      download_mode <= 1'b0;
      ext_program_mem <= 1'b0;
      emulation_mode <= 1'b0;
    end else begin
      rst_prev_q <= any_reset;
      if (rst_prev_q && !any_reset) begin
        download_mode <= ~s_strobe;
        emulation_mode <= s_emu;
        ext_program_mem <= ~s_ea & ~s_emu;
      end
    end
  end

  // Strobe pin drives except while reset is held, when it is sampled
  assign program_strobe_pin_oe = ~any_reset;

  // Clock and pad controls registered per mode
  // Registered so that pads and clock gates never see a glitch from
  // the state decode; the cost is one cycle of lag after each change.
  // The interval counter clock is never gated here; its own enable
  // lives with the counter.
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      core_reset <= 1'b1;
      core_clk_en <= 1'b0;
      pll_en <= 1'b1;
      osc_en <= 1'b1;
      periph_clk_en <= 1'b0;
      interval_counter_clk_en <= 1'b1;
      hold_state <= 1'b0;
      dac_out_hiz <= 1'b0;
      wake_irq_service <= 1'b0;
    end else begin
      core_reset <= any_reset;
      core_clk_en <= (state_q == ST_RUN) & ~any_reset;
      pll_en <= (state_q != ST_PDOWN);
      osc_en <= (state_q != ST_PDOWN) | ~clkcfg_q[`PMR_CLK_OSC_PD];
      periph_clk_en <= (state_q != ST_PDOWN);
      interval_counter_clk_en <= 1'b1;
      hold_state <= (state_q != ST_RUN);
      dac_out_hiz <= (state_q == ST_PDOWN);
      wake_irq_service <= (state_q == ST_PDOWN) & pd_wake & ~any_reset;
    end
  end

  // AXI read path, one outstanding read
  // Reads answer one cycle after the address is taken; the status
  // word is read-only and writes to it are ignored with an okay.
  assign s_axi_arready = ~s_axi_rvalid;
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mapped(s_axi_araddr) ? 2'b00 : 2'b10;
      case (s_axi_araddr[7:0])
        `PMR_OFS_CLKCFG: s_axi_rdata <= clkcfg_q;
        `PMR_OFS_PWRCTL: s_axi_rdata <= pwrctl_q;
        `PMR_OFS_STATUS: s_axi_rdata <= {27'h0, download_mode,
                                          emulation_mode, ext_program_mem,
                                          state_q};
        `PMR_OFS_WAKE: s_axi_rdata <= {28'h0, wake_cause_q};
        default: s_axi_rdata <= 32'h00000000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // pmr_power_ctrl

/* File: pmr_defines.vh */
`ifndef PMR_DEFINES_VH
`define PMR_DEFINES_VH
// Register byte offsets
`define PMR_OFS_CLKCFG 8'h00
`define PMR_OFS_PWRCTL 8'h04
`define PMR_OFS_STATUS 8'h08
`define PMR_OFS_WAKE 8'h0c
// Clock configuration register fields
`define PMR_CLK_OSC_PD 0
`define PMR_CLKCFG_RST 32'h00000000
// Power control register fields
`define PMR_PC_IDLE 0
`define PMR_PC_PDOWN 1
`define PMR_PC_SER_WAKE 2
`define PMR_PC_EXTERNAL_INTERRUPT_ZERO_PIN_WAKE 3
`define PMR_PWRCTL_RST 32'h00000000
// Wake cause bits
`define PMR_WK_IC 0
`define PMR_WK_SER 1
`define PMR_WK_EXTERNAL_INTERRUPT_ZERO_PIN 2
`define PMR_WK_OTHER 3
// Timing: power-on hold 128 ms at 250 MHz (4 ns)
`define PMR_POR_HOLD_MS 128
`define PMR_CLK_NS 4
`define PMR_POR_CYCLES ((`PMR_POR_HOLD_MS * 1000000) / `PMR_CLK_NS)
`endif

/* File: pmr_power_ctrl_asserts.sv */
`timescale 1ns/1ns
// Mode outputs tied to their causes at the pins
module pmr_power_ctrl_asserts (
  input wire clock,
  input wire rst_b,
  input wire supply_ok,
  input wire reset_pin_b,
  input wire irq_pending,
  input wire interval_counter_irq,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire core_reset,
  input wire core_clk_en,
  input wire pll_en,
  input wire periph_clk_en,
  input wire dac_out_hiz
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  // Two cycles out of reset first, so release edges are not judged
  sequence idle_s;
    !core_reset ##1 !core_reset && !core_clk_en && pll_en;
  endsequence
  sequence pdown_s;
    !core_reset ##1 !core_reset && !pll_en;
  endsequence
  a_pdown_clocks: assert property (pdown_s |->
    !core_clk_en && !periph_clk_en) else $error("clock on in power-down");
  a_pdown_hiz: assert property (pdown_s |-> dac_out_hiz)
    else $error("converter driven in power-down");
  a_idle_wake: assert property (idle_s ##0 irq_pending |->
    ##[1:8] core_clk_en) else $error("idle kept on interrupt");
  a_tick_wake: assert property (pdown_s ##0 interval_counter_irq |->
    ##[1:8] pll_en) else $error("no wake on tick");
  a_pin_reset: assert property ($fell(reset_pin_b) |->
    ##[1:6] core_reset) else $error("reset pin ignored");
  a_supply_reset: assert property (!supply_ok |->
    ##[1:6] core_reset) else $error("low supply ignored");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
endmodule // pmr_power_ctrl_asserts

bind pmr_power_ctrl pmr_power_ctrl_asserts i_pmr_power_ctrl_asserts (.*);

/* File: pmr_far_side.sv */
`timescale 1ns/1ns
// Supply monitor, reset button, interrupt sources and straps
module pmr_far_side (
  input wire clock,
  input wire program_strobe_pin_oe,
  output logic supply_ok,
  output logic supply_dead,
  output logic reset_pin_b,
  output logic irq_pending,
  output logic interval_counter_irq,
  output logic serial_irq,
  output logic external_interrupt_zero_pin,
  output wire program_strobe_pin_in,
  output logic external_access_pin,
  output logic emul_pullup_seen
);
  logic jumper_q;
  // Pull-up holds the strap high; only the jumper pulls it low
  assign program_strobe_pin_in = program_strobe_pin_oe | ~jumper_q;
  // Supply starts dead; interrupt zero pin rests high
  initial begin
    {supply_ok, irq_pending, interval_counter_irq, serial_irq} = 4'h0;
    {supply_dead, reset_pin_b, external_interrupt_zero_pin} = 3'h7;
    {jumper_q, external_access_pin, emul_pullup_seen} = 3'h0;
  end
  // Every change lands just after a rising edge
  task supply(input logic ok, input logic dead);
    @(posedge clock);
    supply_ok <= ok;
    supply_dead <= dead;
  endtask
  task irqs(input logic p, input logic t, input logic s, input logic z_b);
    @(posedge clock);
    {irq_pending, interval_counter_irq, serial_irq} <= {p, t, s};
    external_interrupt_zero_pin <= z_b;
  endtask
  task pin_reset(input logic v);
    @(posedge clock);
    reset_pin_b <= v;
  endtask
  task straps(input logic j, input logic x, input logic e);
    @(posedge clock);
    {jumper_q, external_access_pin, emul_pullup_seen} <= {j, x, e};
  endtask
endmodule // pmr_far_side

/* File: pmr_power_ctrl_test.sv */
`timescale 1ns/1ns
module pmr_power_ctrl_test;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire supply_ok, supply_dead, reset_pin_b, irq_pending, interval_counter_irq;
  wire serial_irq, external_interrupt_zero_pin, program_strobe_pin_in;
  wire external_access_pin, emul_pullup_seen, program_strobe_pin_oe;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire core_reset, core_clk_en, pll_en, osc_en, periph_clk_en, hold_state;
  wire interval_counter_clk_en, dac_out_hiz, wake_irq_service, download_mode;
  wire ext_program_mem, emulation_mode;
  int mismatches = 0;
  int n_checks = 0;
  logic [31:0] rd_q;
  logic [1:0] rr_q;
  logic [1:0] br_q;

  // Short power-on hold keeps the run brief
  pmr_power_ctrl #(.POR_CYCLES(20)) i_pmr_power_ctrl (.*);
  pmr_far_side i_pmr_far_side (.*);

  // 250 MHz clock
  always #2 clock = ~clock;

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task give_verdict;
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Address and data offered together, each dropped once taken
  task wr(input logic [31:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge clock);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (aw || w) begin
      @(posedge clock);
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clock); while (s_axi_bvalid !== 1'b1);
    br_q = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [31:0] a);
    @(posedge clock);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge clock); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clock); while (s_axi_rvalid !== 1'b1);
    {rr_q, rd_q} = {s_axi_rresp, s_axi_rdata};
    s_axi_rready <= 1'b0;
  endtask
  // Bounded wait for the held reset to let go
  task wait_run;
    for (int i = 0; i < 80 && core_reset !== 1'b0; i++) @(posedge clock);
  endtask

  // Power-on hold, straps, defaults and an unmapped read
  task t_power_on;
    i_pmr_far_side.supply(1'b1, 1'b0);
    cyc(4);
    chk({core_reset, program_strobe_pin_oe}, 2'h2);
    wait_run;
    cyc(2);
    chk({core_reset, download_mode, ext_program_mem}, 3'h1);
    chk(program_strobe_pin_oe, 1'b1);
    rd(32'h0);
    chk(rd_q, 32'h0);
    rd(32'h10);
    chk(rr_q, 2'h2);
  endtask
  // Idle stops only the core clock; an interrupt ends it
  task t_idle;
    wr(32'h4, 32'h1);
    chk(br_q, 2'h0);
    cyc(3);
    chk({core_clk_en, osc_en, periph_clk_en, hold_state}, 4'h7);
    rd(32'h8);
    chk(rd_q, 32'h5);
    i_pmr_far_side.irqs(1'b1, 1'b0, 1'b0, 1'b1);
    cyc(8);
    chk(core_clk_en, 1'b1);
    i_pmr_far_side.irqs(1'b0, 1'b0, 1'b0, 1'b1);
  endtask
  // Power-down; a source with its enable clear must not wake it
  task t_pdown(input logic osc_pd, input int src);
    logic [2:0] good, bad;
    good = 3'h4 >> src;
    bad = (src == 1) ? 3'h1 : 3'h2;
    wr(32'h0, {31'h0, osc_pd});
    wr(32'h4, {28'h0, src == 2, src == 1, 2'h2});
    cyc(3);
    chk({pll_en, core_clk_en, periph_clk_en, dac_out_hiz, osc_en,
      interval_counter_clk_en}, {4'h1, !osc_pd, 1'b1});
    rd(32'h8);
    chk(rd_q, 32'h6);
    i_pmr_far_side.irqs(1'b0, bad[2], bad[1], !bad[0]);
    cyc(8);
    chk(pll_en, 1'b0);
    i_pmr_far_side.irqs(1'b0, good[2], good[1], !good[0]);
    cyc(8);
    chk({pll_en, core_clk_en}, 2'h3);
    rd(32'hc);
    chk(rd_q & (32'h1 << src), 32'h1 << src);
    i_pmr_far_side.irqs(1'b0, 1'b0, 1'b0, 1'b1);
    wr(32'hc, 32'hf);
  endtask
  // Reset pin in power-down with download jumper and emulation pull-up
  task t_pin_reset;
    wr(32'h0, 32'h1);
    wr(32'h4, 32'he);
    i_pmr_far_side.straps(1'b1, 1'b1, 1'b1);
    i_pmr_far_side.pin_reset(1'b0);
    cyc(8);
    chk({core_reset, program_strobe_pin_oe}, 2'h2);
    i_pmr_far_side.pin_reset(1'b1);
    wait_run;
    cyc(2);
    chk({pll_en, download_mode, emulation_mode, ext_program_mem}, 4'he);
    rd(32'h4);
    chk(rd_q, 32'h0);
    i_pmr_far_side.straps(1'b0, 1'b1, 1'b0);
  endtask
  // Supply sag held through the low threshold, then timed restart
  task t_power_cycle;
    wr(32'h4, 32'hc);
    i_pmr_far_side.supply(1'b0, 1'b0);
    cyc(8);
    chk(core_reset, 1'b1);
    i_pmr_far_side.supply(1'b0, 1'b1);
    i_pmr_far_side.supply(1'b1, 1'b0);
    cyc(10);
    chk(core_reset, 1'b1);
    wait_run;
    cyc(2);
    chk({core_reset, download_mode}, 2'h0);
    rd(32'h4);
    chk(rd_q, 32'h0);
  endtask

  // Main sequence
  initial begin
    cyc(8);
    rst_b <= 1'b1;
    t_power_on;
    t_idle;
    t_pdown(1'b0, 0);
    t_pdown(1'b1, 1);
    t_pdown(1'b0, 2);
    t_pin_reset;
    t_power_cycle;
    give_verdict;
  end
  // Watchdog against a hung handshake
  initial begin
    cyc(4000);
    mismatches++;
    give_verdict;
  end
endmodule // pmr_power_ctrl_test
